// ### tb/dser_host_model.sv
// host model driving the register port
`timescale 1ns/10ps
`default_nettype none
module dser_host_model (
  input  wire logic                    core_clk,
  input  wire logic [7:0]              rdData,
  output var  dser_pkg::dser_bus_req_t busReq
);
  initial busReq = '0;
  // released lines are inverted so stale values cannot pass
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk) busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) busReq <= '{~a, ~d, 1'b0, 1'b0};
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk) busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk) busReq <= '{~a, 8'hff, 1'b0, 1'b0};
    @(negedge core_clk) d = rdData;
  endtask
endmodule
`default_nettype wire

// ### tb/dser_regs_properties.sv
// port checks for the disk status bank
`timescale 1ns/10ps
`default_nettype none
module dser_regs_properties (
  // clock and reset
  input wire logic                    core_clk,
  input wire logic                    sys_rst,
  // register port
  input wire dser_pkg::dser_bus_req_t busReq,
  input wire logic [7:0]              rdData,
  // drive side and interrupt
  input wire dser_pkg::dser_drive_t   driveIn,
  input wire logic                    cmdDone,
  input wire dser_pkg::dser_fault_t   faultIn,
  input wire logic                    cmdStart,
  input wire logic                    irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire logic [7:0] causeExp = {faultIn[4:3], 1'b0, faultIn[2], 1'b0, faultIn[1:0], 1'b0};
  wire logic       rdSt = busReq.rd && busReq.addr == 4'h0;
  wire logic       rdCf = busReq.rd && busReq.addr == 4'h1;
  logic [7:0] causeReg;
  logic [3:0] maskReg;
  logic       errReg;
  // ====
  // shadow state, so reads can be tied to earlier events
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {causeReg, maskReg, errReg} <= '0;
    end else begin
      if (cmdDone) {causeReg, errReg} <= {causeExp, |faultIn};
      else if (cmdStart) errReg <= 1'b0;
      if (busReq.wr && busReq.addr == 4'h3) maskReg <= busReq.wdata[3:0];
    end
  end
  a_status_live: assert property (rdSt |=> rdData[7:1] == $past(driveIn))
    else $error("status flags wrong");
  a_err_flag: assert property (rdSt |=> rdData[0] == $past(errReg))
    else $error("error flag wrong");
  a_cause_map: assert property (rdCf |=> rdData == $past(causeReg))
    else $error("cause wrong");
  a_unused_zero: assert property (rdCf |=> (rdData & 8'h29) == 8'h00)
    else $error("unused cause bits set");
  a_data_idle: assert property (!busReq.rd |=> rdData == 8'h00)
    else $error("read data outside answer");
  a_unmapped_read: assert property (busReq.rd && busReq.addr > 4'h3 |=> rdData == 8'h00)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (irq |-> maskReg != 4'h0)
    else $error("irq with all masked");
  a_irq_reset: assert property ($fell(sys_rst) |-> !irq)
    else $error("irq after reset");
endmodule
bind dser_regs dser_regs_properties u_dser_regs_properties (.core_clk, .sys_rst, .busReq,
  .rdData, .driveIn, .cmdDone, .faultIn, .cmdStart, .irq);
`default_nettype wire

// ### tb/dser_regs_tb_top.sv
// self-checking bench for the disk status bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module dser_regs_tb_top;
  logic                    core_clk = 0, sys_rst = 1, cmdDone = 0, cmdStart = 0, irq;
  logic [7:0]              rdData, v;
  dser_pkg::dser_bus_req_t busReq;
  dser_pkg::dser_drive_t   driveIn = '0;
  dser_pkg::dser_fault_t   faultIn = '0;
  int                      errors = 0, n_tests = 0, i;
  // rows: drive flags, fault flags, status, cause
  logic [27:0]             rows[4] = '{{7'h00, 5'h1f, 8'h01, 8'hd6}, {7'h55, 5'h14, 8'hab, 8'h90},
                                       {7'h2a, 5'h0b, 8'h55, 8'h46}, {7'h7f, 5'h00, 8'hfe, 8'h00}};
  always #10 core_clk = ~core_clk;
  dser_regs u_dser_regs (.core_clk, .sys_rst, .busReq, .rdData, .driveIn, .cmdDone,
                         .faultIn, .cmdStart, .irq);
  dser_host_model u_dser_host_model (.core_clk, .rdData, .busReq);
  task automatic finish_cmd(input logic [4:0] f);
    @(posedge core_clk) {cmdDone, faultIn} <= {1'b1, f};
    @(posedge core_clk) cmdDone <= 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [3:0] a, input logic [7:0] e);
    u_dser_host_model.rd(a, v);
    `CHK(n, e, v)
  endtask
  task automatic conclude();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ====
  // sequence
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk) driveIn <= rows[i][27:21];
      finish_cmd(rows[i][20:16]);
      rd_chk("status", 4'h0, rows[i][15:8]);
      rd_chk("cause", 4'h1, rows[i][7:0]);
    end
    finish_cmd(5'h02);
    @(posedge core_clk) cmdStart <= 1'b1;
    @(posedge core_clk) cmdStart <= 1'b0;
    rd_chk("errclr", 4'h0, 8'hfe);
    u_dser_host_model.wr(4'h1, 8'hff);
    rd_chk("ro", 4'h1, 8'h04);
    rd_chk("unmap", 4'h9, 8'h00);
    u_dser_host_model.rd(4'h2, v);
    u_dser_host_model.wr(4'h3, 8'h02);
    finish_cmd(5'h00);
    @(negedge core_clk) `CHK("masked", 1'b0, irq)
    finish_cmd(5'h10);
    @(negedge core_clk) `CHK("irq", 1'b1, irq)
    rd_chk("irqst", 4'h2, 8'h03);
    `CHK("irqclr", 1'b0, irq)
    rd_chk("mask", 4'h3, 8'h02);
    @(posedge core_clk) driveIn <= '0;
    @(posedge core_clk) driveIn <= 7'h7f;
    rd_chk("irqevt", 4'h2, 8'h0c);
    @(posedge core_clk) sys_rst <= 1'b1;
    @(posedge core_clk) sys_rst <= 1'b0;
    rd_chk("rstcause", 4'h1, 8'h00);
    rd_chk("rststat", 4'h0, 8'hfe);
    rd_chk("rstmask", 4'h3, 8'h00);
    conclude();
  end
  initial begin
    #20000;
    errors++;
    conclude();
  end
endmodule
`default_nettype wire

// ### verilog/dser_params.svh
// constants for the disk status and fault cause register bank
`ifndef DSER_PARAMS_SVH
`define DSER_PARAMS_SVH
// ==========================================================
// register offsets
`define DSER_ADDR_W        4
`define DSER_OFF_STATUS    4'h0
`define DSER_OFF_CAUSE     4'h1
`define DSER_OFF_IRQ_STAT  4'h2
`define DSER_OFF_IRQ_MASK  4'h3
// ==========================================================
// status bit positions
`define DSER_ST_BUSY       7
`define DSER_ST_READY      6
`define DSER_ST_WFAULT     5
`define DSER_ST_SEEK       4
`define DSER_ST_XFER       3
`define DSER_ST_FIXED      2
`define DSER_ST_INDEX      1
`define DSER_ST_ERR        0
// ==========================================================
// fault cause bit positions
`define DSER_FC_BADBLK     7
`define DSER_FC_UNFIX      6
`define DSER_FC_IDMISS     4
`define DSER_FC_ABORT      2
`define DSER_FC_TRK0       1
`define DSER_FC_USED_MASK  8'hd6
// ==========================================================
// interrupt event bits
`define DSER_IRQ_DONE      0
`define DSER_IRQ_ERR       1
`define DSER_IRQ_XFER      2
`define DSER_IRQ_INDEX     3
`define DSER_IRQ_USED_MASK 8'h0f
`define DSER_RESET_BYTE    8'h00
`endif

// ### verilog/dser_pkg.sv
// types for the disk status and fault cause register bank
package dser_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dser_bus_req_t;

  typedef struct packed {
    logic busy;
    logic ready;
    logic wfault;
    logic seekDone;
    logic xferReq;
    logic fixedData;
    logic indexMark;
  } dser_drive_t;

  typedef struct packed {
    logic badBlock;
    logic unfixable;
    logic idMissing;
    logic aborted;
    logic trk0Missing;
  } dser_fault_t;
endpackage

// ### verilog/dser_regs.sv
// disk status and fault cause register bank with event interrupt
// Functional notes
// - bit7 busy, bit6 ready for command
// - bit5 shows write fault
// - bit4 shows heads settled after seek
// - bit3 shows data word transfer possible
// - bit2 corrected data, bit1 index sensed
// - bit0 previous command ended in error
// - cause bit7 bad block mark seen
// - cause bit6 uncorrectable data error
// - cause bit4 sector ID field missing
// - cause bit2 command aborted
// - cause bit1 track zero not found
`include "dser_params.svh"
`timescale 1ns/10ps
`default_nettype none

module dser_regs (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // register port
  input  wire dser_pkg::dser_bus_req_t busReq,
  output logic [7:0]                rdData,
  // drive condition inputs
  input  wire dser_pkg::dser_drive_t   driveIn,
  // command start and completion
  input  wire logic                 cmdDone,
  input  wire dser_pkg::dser_fault_t   faultIn,
  input  wire logic                 cmdStart,
  // interrupt
  output logic                      irq
);

  // ==========================================================
  // completion capture
  logic        errReg;
  logic        errNext;
  logic [7:0]  causeReg;
  logic [7:0]  causeNext;
  logic [7:0]  faultByte;
  logic [7:0]  statusByte;

  assign faultByte = {faultIn.badBlock,
                      faultIn.unfixable,
                      1'b0,
                      faultIn.idMissing,
                      1'b0,
                      faultIn.aborted,
                      faultIn.trk0Missing,
                      1'b0} & `DSER_FC_USED_MASK;

  // cause stays until the next completion so software can read it late
  assign causeNext = cmdDone ? faultByte : causeReg;
  // a new command clears the error; completion in same cycle wins
  assign errNext   = cmdDone ? (faultByte != 8'h00) :
                     (cmdStart ? 1'b0 : errReg);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      causeReg <= `DSER_RESET_BYTE;
      errReg   <= 1'b0;
    end else begin
      causeReg <= causeNext;
      errReg   <= errNext;
    end
  end

  assign statusByte = {driveIn.busy,
                       driveIn.ready,
                       driveIn.wfault,
                       driveIn.seekDone,
                       driveIn.xferReq,
                       driveIn.fixedData,
                       driveIn.indexMark,
                       errReg};

  // ==========================================================
  // interrupt events
  logic       xferPrev;
  logic       idxPrev;
  logic [7:0] evtByte;
  logic [7:0] irqStatReg;
  logic [7:0] irqStatNext;
  logic [7:0] irqMaskReg;
  logic [7:0] irqMaskNext;

  // tracked through reset so a pin idling high gives no false rise
  always_ff @(posedge core_clk) begin
    xferPrev <= driveIn.xferReq;
    idxPrev  <= driveIn.indexMark;
  end

  assign evtByte = {4'h0,
                    driveIn.indexMark & ~idxPrev,
                    driveIn.xferReq & ~xferPrev,
                    cmdDone & (faultByte != 8'h00),
                    cmdDone};

  // ==========================================================
  // register decode
  wire selStatus = busReq.addr == `DSER_OFF_STATUS;
  wire selCause  = busReq.addr == `DSER_OFF_CAUSE;
  wire selIStat  = busReq.addr == `DSER_OFF_IRQ_STAT;
  wire selIMask  = busReq.addr == `DSER_OFF_IRQ_MASK;
  wire rdIStat   = busReq.rd & selIStat;

  // status and cause are read only, writes dropped
  // set beats the read clear so an event in that cycle survives
  assign irqStatNext = (rdIStat ? 8'h00 : irqStatReg) | evtByte;
  assign irqMaskNext = (busReq.wr & selIMask) ?
                       (busReq.wdata & `DSER_IRQ_USED_MASK) : irqMaskReg;

  wire [7:0] rdMux = selStatus ? statusByte :
                     selCause  ? causeReg   :
                     selIStat  ? irqStatReg :
                     selIMask  ? irqMaskReg : 8'h00;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqStatReg <= `DSER_RESET_BYTE;
      irqMaskReg <= `DSER_RESET_BYTE;
      rdData     <= `DSER_RESET_BYTE;
    end else begin
      irqStatReg <= irqStatNext;
      irqMaskReg <= irqMaskNext;
      rdData     <= busReq.rd ? rdMux : 8'h00;
    end
  end

  assign irq = |(irqStatReg & irqMaskReg);

endmodule

`default_nettype wire
